// ### shared/stepdrv_consts.svh
`ifndef STEPDRV_CONSTS_SVH
`define STEPDRV_CONSTS_SVH

// register byte offsets
`define REG_STATUS 5'h00
`define REG_MASK 5'h04
`define REG_STATE 5'h08
`define REG_POSITION 5'h0C
`define REG_CONTROL 5'h10
`define REG_USTEP 5'h14

// status and mask bit positions
`define ST_STEP 0
`define ST_OVER_VOLT 1
`define ST_UNDER_VOLT 2
`define ST_OVER_CURR 3
`define ST_WIRING 4
`define ST_INTERNAL 5
`define ST_IDLE 6
`define ST_BLOCKED 7
`define ST_WIDTH 8

// control bit positions
`define CTL_SOFT_DIS 0
`define CTL_POS_CLR 1

// reset values
`define MASK_RST 8'h00
`define CONTROL_RST 1'h0

// phase current levels in mA, code 0 to 7
`define CUR_MA_0 13'h07D0
`define CUR_MA_1 13'h0A0A
`define CUR_MA_2 13'h0C44
`define CUR_MA_3 13'h0E7E
`define CUR_MA_4 13'h10B8
`define CUR_MA_5 13'h12FC
`define CUR_MA_6 13'h1536
`define CUR_MA_7 13'h1770

// decimal microstep divisors
`define RES_DEC_0 9'h005
`define RES_DEC_1 9'h00A
`define RES_DEC_2 9'h019
`define RES_DEC_3 9'h032
`define RES_DEC_4 9'h07D
`define RES_DEC_5 9'h0FA
`define RES_POW2_BASE 9'h002

// timing
`define CLK_KHZ 40000
`define IDLE_TIME_MS 500
`define IDLE_CYCLES (`IDLE_TIME_MS * `CLK_KHZ)

`endif

// ### shared/stepdrv_pkg.sv
package stepdrv_pkg;
  typedef enum logic [1:0] {DS_OFF, DS_RUN, DS_STANDSTILL} drive_state_t;
endpackage

// ### hw/sync_bits.sv
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  generate
    if (W < 1)
    begin : g_chk
      $error("sync_bits needs W of at least 1");
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta;
      always_ff @(posedge i_mclk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          meta <= 1'b0;
          o_q[g] <= 1'b0;
        end
        else
        begin
          meta <= i_d[g];
          o_q[g] <= meta;
        end
      end
    end
  endgenerate
endmodule

// ### hw/switch_decode.sv
`timescale 1ns/1ps
`include "stepdrv_consts.svh"
module switch_decode (
  // switch codes
  input wire logic [2:0] i_cur_code,
  input wire logic i_res_family_sel,
  input wire logic [2:0] i_res_code,
  // decoded settings
  output logic [12:0] o_run_ma,
  output logic [8:0] o_res_div,
  output logic o_res_valid
);
  always_comb
  begin
    case (i_cur_code)
      3'h0: o_run_ma = `CUR_MA_0;
      3'h1: o_run_ma = `CUR_MA_1;
      3'h2: o_run_ma = `CUR_MA_2;
      3'h3: o_run_ma = `CUR_MA_3;
      3'h4: o_run_ma = `CUR_MA_4;
      3'h5: o_run_ma = `CUR_MA_5;
      3'h6: o_run_ma = `CUR_MA_6;
      default: o_run_ma = `CUR_MA_7;
    endcase
  end

  always_comb
  begin
    o_res_valid = 1'b1;
    if (!i_res_family_sel)
      o_res_div = `RES_POW2_BASE << i_res_code;
    else
    begin
      case (i_res_code)
        3'h0: o_res_div = `RES_DEC_0;
        3'h1: o_res_div = `RES_DEC_1;
        3'h2: o_res_div = `RES_DEC_2;
        3'h3: o_res_div = `RES_DEC_3;
        3'h4: o_res_div = `RES_DEC_4;
        3'h5: o_res_div = `RES_DEC_5;
        // undefined codes: fall back to the finest decimal setting
        default:
        begin
          o_res_div = `RES_DEC_5;
          o_res_valid = 1'b0;
        end
      endcase
    end
  end
endmodule

// ### hw/microstep_step_dir_controller.sv
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "stepdrv_consts.svh"
// Summary of operation
// - three switches pick eight current levels
// - standstill-select off halves idle current
// - standstill-select on keeps full current
// - family 0 gives power-of-two microsteps
// - family 1 gives six decimal microsteps
// - undriven enable input means drive enabled
// - disabled drive ignores all step pulses
// - supply or current faults stop drive
// - faults light the alarm lamp
module microstep_step_dir_controller #(
  parameter int IDLE_CYCLES = `IDLE_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // isolated control inputs; drive_allow_in high means disable asserted
  input wire logic i_step_pulse_in,
  input wire logic i_dir_in,
  input wire logic i_drive_allow_in,
  // configuration switches, on reads 0
  input wire logic i_current_sel_b0,
  input wire logic i_current_sel_b1,
  input wire logic i_current_sel_b2,
  input wire logic i_idle_current_sel,
  input wire logic i_res_family_sel,
  input wire logic i_res_sel_b0,
  input wire logic i_res_sel_b1,
  input wire logic i_res_sel_b2,
  // fault detectors
  input wire logic i_over_volt,
  input wire logic i_under_volt,
  input wire logic i_over_curr,
  input wire logic i_wiring_fault,
  input wire logic i_internal_fault,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // motor drive
  output logic o_drive_en,
  output logic [12:0] o_current_ma,
  output logic [7:0] o_ustep_pos,
  output logic [1:0] o_full_step,
  output logic [8:0] o_res_div,
  output logic o_fault_lamp,
  output logic o_irq
);
  generate
    if (IDLE_CYCLES < 2)
    begin : g_chk
      $error("IDLE_CYCLES must be at least 2");
    end
  endgenerate

  //****************************************************************
  // input synchronisation
  //****************************************************************
  logic [15:0] pins_s;
  logic step_s, dir_s, inhibit_s, idle_sel;
  logic [2:0] cur_code, res_code;
  logic res_fam;
  logic [4:0] fault_s;
  logic step_prev;
  logic [4:0] fault_prev;

  sync_bits #(
    .W(16)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_d({i_internal_fault, i_wiring_fault, i_over_curr, i_under_volt,
      i_over_volt, i_res_sel_b2, i_res_sel_b1, i_res_sel_b0,
      i_res_family_sel, i_idle_current_sel, i_current_sel_b2,
      i_current_sel_b1, i_current_sel_b0, i_drive_allow_in, i_dir_in,
      i_step_pulse_in}),
    .o_q(pins_s)
  );

  assign step_s = pins_s[0];
  assign dir_s = pins_s[1];
  assign inhibit_s = pins_s[2];
  assign cur_code = pins_s[5:3];
  assign idle_sel = pins_s[6];
  assign res_fam = pins_s[7];
  assign res_code = pins_s[10:8];
  assign fault_s = pins_s[15:11];

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      step_prev <= 1'b0;
      fault_prev <= 5'h00;
    end
    else
    begin
      step_prev <= step_s;
      fault_prev <= fault_s;
    end
  end

  logic step_edge;
  logic fault_any;
  assign step_edge = step_s & ~step_prev;
  assign fault_any = |fault_s;

  //****************************************************************
  // switch decode
  //****************************************************************
  logic [12:0] run_ma;
  logic [8:0] res_div;
  logic res_valid;

  switch_decode u_dec (
    .i_cur_code(cur_code),
    .i_res_family_sel(res_fam),
    .i_res_code(res_code),
    .o_run_ma(run_ma),
    .o_res_div(res_div),
    .o_res_valid(res_valid)
  );

  //****************************************************************
  // drive state
  //****************************************************************
  stepdrv_pkg::drive_state_t state, next_state;
  logic soft_dis;
  logic allow;
  logic [31:0] idle_cnt;
  logic idle_done;
  // open enable pair leaves the opto dark, which reads 0 = enabled
  assign allow = ~inhibit_s & ~fault_any & ~soft_dis;
  assign idle_done = (idle_cnt >= 32'(IDLE_CYCLES - 1));

  always_comb
  begin
    next_state = state;
    case (state)
      stepdrv_pkg::DS_OFF:
        if (allow)
          next_state = stepdrv_pkg::DS_RUN;
      stepdrv_pkg::DS_RUN:
        if (!allow)
          next_state = stepdrv_pkg::DS_OFF;
        else if (idle_done && !step_edge)
          next_state = stepdrv_pkg::DS_STANDSTILL;
      stepdrv_pkg::DS_STANDSTILL:
        if (!allow)
          next_state = stepdrv_pkg::DS_OFF;
        else if (step_edge)
          next_state = stepdrv_pkg::DS_RUN;
      default:
        next_state = stepdrv_pkg::DS_OFF;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      state <= stepdrv_pkg::DS_OFF;
    else
      state <= next_state;
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      idle_cnt <= 32'h0000_0000;
    else if (step_edge || state != stepdrv_pkg::DS_RUN)
      idle_cnt <= 32'h0000_0000;
    else if (!idle_done)
      idle_cnt <= idle_cnt + 32'h0000_0001;
  end

  logic drive_go;
  assign drive_go = (state != stepdrv_pkg::DS_OFF) & allow;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_drive_en <= 1'b0;
      o_current_ma <= 13'h0000;
      o_fault_lamp <= 1'b0;
      o_res_div <= `RES_POW2_BASE;
    end
    else
    begin
      o_drive_en <= allow;
      o_fault_lamp <= fault_any;
      o_res_div <= res_div;
      if (!allow)
        o_current_ma <= 13'h0000;
      else if (state == stepdrv_pkg::DS_STANDSTILL && idle_sel)
        o_current_ma <= run_ma >> 1;
      else
        o_current_ma <= run_ma;
    end
  end

  //****************************************************************
  // microstep position
  //****************************************************************
  // the 75 kpps ceiling is far below the edge detector's reach, so
  // the far side's rate limit costs no logic here
  logic [31:0] position;
  logic pos_clr;
  logic [7:0] ustep_top;
  logic do_step;
  assign ustep_top = 8'(res_div - 9'h001);
  assign do_step = step_edge & drive_go;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_ustep_pos <= 8'h00;
      o_full_step <= 2'h0;
      position <= 32'h0000_0000;
    end
    else if (pos_clr)
    begin
      o_ustep_pos <= 8'h00;
      o_full_step <= 2'h0;
      position <= 32'h0000_0000;
    end
    else if (do_step)
    begin
      if (dir_s)
      begin
        position <= position + 32'h0000_0001;
        // a resolution change mid-step may leave pos past the top
        if (o_ustep_pos >= ustep_top)
        begin
          o_ustep_pos <= 8'h00;
          o_full_step <= o_full_step + 2'h1;
        end
        else
          o_ustep_pos <= o_ustep_pos + 8'h01;
      end
      else
      begin
        position <= position - 32'h0000_0001;
        if (o_ustep_pos == 8'h00)
        begin
          o_ustep_pos <= ustep_top;
          o_full_step <= o_full_step - 2'h1;
        end
        else if (o_ustep_pos > ustep_top)
          o_ustep_pos <= ustep_top;
        else
          o_ustep_pos <= o_ustep_pos - 8'h01;
      end
    end
  end

  //****************************************************************
  // register bus
  //****************************************************************
  logic ack;
  logic [7:0] status, mask, status_set, status_clr;
  logic wr_take, rd_take;
  logic [31:0] be_mask;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign wr_take = i_avs_write & ack;
  assign rd_take = i_avs_read & ~ack;
  assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      ack <= 1'b0;
    else
      ack <= (i_avs_read | i_avs_write) & ~ack;
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_avs_readdata <= 32'h0000_0000;
    else if (rd_take)
    begin
      case (i_avs_address)
        `REG_STATUS: o_avs_readdata <= {24'h000000, status};
        `REG_MASK: o_avs_readdata <= {24'h000000, mask};
        `REG_STATE: o_avs_readdata <= {7'h00, res_div, res_valid,
          fault_s, state == stepdrv_pkg::DS_STANDSTILL, o_drive_en,
          res_code, res_fam, idle_sel, cur_code};
        `REG_POSITION: o_avs_readdata <= position;
        `REG_CONTROL: o_avs_readdata <= {31'h0000_0000, soft_dis};
        `REG_USTEP: o_avs_readdata <= {22'h00_0000, o_full_step,
          o_ustep_pos};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mask <= `MASK_RST;
      soft_dis <= `CONTROL_RST;
    end
    else if (wr_take)
    begin
      if (i_avs_address == `REG_MASK && i_avs_byteenable[0])
        mask <= i_avs_writedata[7:0];
      if (i_avs_address == `REG_CONTROL && i_avs_byteenable[0])
        soft_dis <= i_avs_writedata[`CTL_SOFT_DIS];
    end
  end

  assign pos_clr = wr_take & (i_avs_address == `REG_CONTROL) &
    i_avs_byteenable[0] & i_avs_writedata[`CTL_POS_CLR];

  //****************************************************************
  // interrupts
  //****************************************************************
  assign status_set = {step_edge & ~drive_go,
    (state == stepdrv_pkg::DS_RUN) &
      (next_state == stepdrv_pkg::DS_STANDSTILL),
    fault_s & ~fault_prev, do_step};
  assign status_clr = (wr_take && i_avs_address == `REG_STATUS) ?
    (i_avs_writedata[7:0] & be_mask[7:0]) : 8'h00;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      status <= 8'h00;
    else
      status <= (status & ~status_clr) | status_set;
  end

  assign o_irq = |(status & mask);

  //****************************************************************
  // checks
  //****************************************************************
  property p_cur_lo;
    @(posedge i_mclk) disable iff (!i_rstn)
    (cur_code == 3'h0) |-> (run_ma == 13'h07D0);
  endproperty
  a_cur_lo: assert property (p_cur_lo) else $error("bad low current");

  property p_half;
    @(posedge i_mclk) disable iff (!i_rstn)
    (allow && state == stepdrv_pkg::DS_STANDSTILL && idle_sel) |=>
      (o_current_ma == ($past(run_ma) >> 1));
  endproperty
  a_half: assert property (p_half) else $error("idle not halved");

  property p_full;
    @(posedge i_mclk) disable iff (!i_rstn)
    (allow && !idle_sel) |=> (o_current_ma == $past(run_ma));
  endproperty
  a_full: assert property (p_full) else $error("idle not full");

  property p_pow2;
    @(posedge i_mclk) disable iff (!i_rstn)
    (!res_fam && res_code == 3'h7) |-> (res_div == 9'h100);
  endproperty
  a_pow2: assert property (p_pow2) else $error("bad 256 divisor");

  property p_dec;
    @(posedge i_mclk) disable iff (!i_rstn)
    (res_fam && res_code == 3'h4) |-> (res_div == 9'h07D);
  endproperty
  a_dec: assert property (p_dec) else $error("bad 125 divisor");

  property p_allow;
    @(posedge i_mclk) disable iff (!i_rstn)
    (!inhibit_s && !fault_any && !soft_dis) |=> o_drive_en;
  endproperty
  a_allow: assert property (p_allow) else $error("drive not on");

  property p_block;
    @(posedge i_mclk) disable iff (!i_rstn)
    (inhibit_s && !pos_clr) |=> $stable(position) && !o_drive_en;
  endproperty
  a_block: assert property (p_block) else $error("moved disabled");

  property p_fault;
    @(posedge i_mclk) disable iff (!i_rstn)
    fault_any |=> (!o_drive_en && o_current_ma == 13'h0000 && o_fault_lamp);
  endproperty
  a_fault: assert property (p_fault) else $error("fault ignored");

  property p_step;
    @(posedge i_mclk) disable iff (!i_rstn)
    (do_step && dir_s && !pos_clr) |=> (position == $past(position) + 1);
  endproperty
  a_step: assert property (p_step) else $error("step lost");

  property p_wake;
    @(posedge i_mclk) disable iff (!i_rstn)
    (state == stepdrv_pkg::DS_STANDSTILL && step_edge && allow) |=>
      (state == stepdrv_pkg::DS_RUN);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on step");

  c_fwd: cover property (@(posedge i_mclk) do_step && dir_s);
  c_idle: cover property (@(posedge i_mclk)
    state == stepdrv_pkg::DS_STANDSTILL);
  c_fault: cover property (@(posedge i_mclk) fault_any);
endmodule

// ### test/step_source.sv
`timescale 1ns/1ps
module step_source (
  // clock
  input wire logic i_mclk,
  // step link
  output logic o_step,
  output logic o_dir
);
  initial
  begin
    o_step = 1'b0;
    o_dir = 1'b1;
  end

  // ************************************
  // pulse train
  // ************************************
  // dir is set four cycles ahead and held, so every edge sees it settled
  task automatic send(input int n, input logic d, input int half);
    @(posedge i_mclk);
    o_dir <= d;
    repeat (4) @(posedge i_mclk);
    for (int k = 0; k < n; k++)
    begin
      o_step <= 1'b1;
      repeat (half) @(posedge i_mclk);
      o_step <= 1'b0;
      repeat (half) @(posedge i_mclk);
    end
  endtask
endmodule

// ### test/microstep_step_dir_controller_test.sv
`timescale 1ns/1ps
`include "stepdrv_consts.svh"
module microstep_step_dir_controller_test;
  typedef struct packed
  {
    logic [2:0] cur;
    logic fam;
    logic [2:0] res;
    logic [12:0] ma;
    logic [8:0] div;
  } row_t;
  row_t rows [14] = '{
    '{3'h0, 1'b0, 3'h0, `CUR_MA_0, 9'h002},
    '{3'h1, 1'b0, 3'h1, `CUR_MA_1, 9'h004},
    '{3'h2, 1'b0, 3'h2, `CUR_MA_2, 9'h008},
    '{3'h3, 1'b0, 3'h3, `CUR_MA_3, 9'h010},
    '{3'h4, 1'b0, 3'h4, `CUR_MA_4, 9'h020},
    '{3'h5, 1'b0, 3'h5, `CUR_MA_5, 9'h040},
    '{3'h6, 1'b0, 3'h6, `CUR_MA_6, 9'h080},
    '{3'h7, 1'b0, 3'h7, `CUR_MA_7, 9'h100},
    '{3'h0, 1'b1, 3'h0, `CUR_MA_0, 9'h005},
    '{3'h1, 1'b1, 3'h1, `CUR_MA_1, 9'h00A},
    '{3'h2, 1'b1, 3'h2, `CUR_MA_2, 9'h019},
    '{3'h3, 1'b1, 3'h3, `CUR_MA_3, 9'h032},
    '{3'h4, 1'b1, 3'h4, `CUR_MA_4, 9'h07D},
    '{3'h5, 1'b1, 3'h5, `CUR_MA_5, 9'h0FA}};
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] cur = 3'h0;
  logic idle_sel = 1'b0;
  logic fam = 1'b0;
  logic [2:0] res = 3'h0;
  logic allow = 1'b0;
  logic [4:0] flt = 5'h00;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic step;
  logic dir;
  logic [31:0] rdata;
  logic waitreq;
  logic drive_en;
  logic [12:0] cur_ma;
  logic [7:0] upos;
  logic [1:0] full;
  logic [8:0] rdiv;
  logic lamp;
  logic irq;
  logic [31:0] rv;
  int errors = 0;
  int checks_done = 0;

  always #12.5 i_mclk = ~i_mclk;

  step_source ss (.i_mclk(i_mclk), .o_step(step), .o_dir(dir));

  microstep_step_dir_controller #(.IDLE_CYCLES(16)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_step_pulse_in(step), .i_dir_in(dir), .i_drive_allow_in(allow),
    .i_current_sel_b0(cur[0]), .i_current_sel_b1(cur[1]),
    .i_current_sel_b2(cur[2]), .i_idle_current_sel(idle_sel),
    .i_res_family_sel(fam), .i_res_sel_b0(res[0]),
    .i_res_sel_b1(res[1]), .i_res_sel_b2(res[2]),
    .i_over_volt(flt[0]), .i_under_volt(flt[1]), .i_over_curr(flt[2]),
    .i_wiring_fault(flt[3]), .i_internal_fault(flt[4]),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .o_drive_en(drive_en), .o_current_ma(cur_ma), .o_ustep_pos(upos),
    .o_full_step(full), .o_res_div(rdiv), .o_fault_lamp(lamp),
    .o_irq(irq));

  // ************************************
  // helpers
  // ************************************
  task automatic finish_test();
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // waitrequest is taken as the rising edge samples it
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0)
    begin
      errors++;
      finish_test();
    end
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    idle(12);
    cmp("res_div in reset", 32'h2, rdiv);
    cmp("drive_en in reset", 32'h0, drive_en);
    i_rstn <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge i_mclk);
      {cur, fam, res} <= {rows[i].cur, rows[i].fam, rows[i].res};
      idle(8);
      cmp("current_ma", rows[i].ma, cur_ma);
      cmp("res_div", rows[i].div, rdiv);
    end
    bus(1'b0, 5'h04, 32'h0);
    cmp("mask reset", 32'h0, rv);
    bus(1'b0, 5'h1C, 32'h0);
    cmp("unmapped read", 32'h0, rv);
    @(posedge i_mclk);
    {fam, res, cur} <= {1'b0, 3'h1, 3'h7};
    idle(6);
    bus(1'b1, 5'h10, 32'h2);
    ss.send(5, 1'b1, 3);
    idle(4);
    bus(1'b0, 5'h0C, 32'h0);
    cmp("position fwd", 32'h5, rv);
    cmp("ustep fwd", 32'h1, upos);
    cmp("full fwd", 32'h1, full);
    ss.send(6, 1'b0, 8);
    idle(4);
    bus(1'b0, 5'h0C, 32'h0);
    cmp("position rev", 32'hFFFFFFFF, rv);
    cmp("ustep rev", 32'h3, upos);
    cmp("full rev", 32'h3, full);
    bus(1'b1, 5'h00, 32'hFF);
    bus(1'b1, 5'h04, 32'h40);
    @(posedge i_mclk);
    idle_sel <= 1'b1;
    ss.send(1, 1'b1, 3);
    idle(30);
    cmp("standstill ma", 32'h0BB8, cur_ma);
    cmp("irq standstill", 32'h1, irq);
    bus(1'b1, 5'h00, 32'h40);
    idle(1);
    cmp("irq cleared", 32'h0, irq);
    ss.send(1, 1'b1, 3);
    cmp("running ma", 32'h1770, cur_ma);
    @(posedge i_mclk);
    allow <= 1'b1;
    idle(6);
    cmp("drive_en off", 32'h0, drive_en);
    cmp("ma off", 32'h0, cur_ma);
    ss.send(3, 1'b1, 3);
    idle(4);
    bus(1'b0, 5'h0C, 32'h0);
    cmp("position held", 32'h1, rv);
    bus(1'b0, 5'h00, 32'h0);
    cmp("blocked flag", 32'h1, rv[7]);
    @(posedge i_mclk);
    allow <= 1'b0;
    idle(6);
    cmp("drive_en on", 32'h1, drive_en);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge i_mclk);
      flt <= 5'h01 << i;
      idle(6);
      cmp("drive_en fault", 32'h0, drive_en);
      cmp("lamp on", 32'h1, lamp);
      bus(1'b0, 5'h00, 32'h0);
      cmp("fault flag", 32'h1, rv[i+1]);
      @(posedge i_mclk);
      flt <= 5'h00;
      idle(6);
      cmp("lamp off", 32'h0, lamp);
    end
    // second reset in mid-run
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    idle(3);
    cmp("res_div rerst", 32'h2, rdiv);
    i_rstn <= 1'b1;
    idle(8);
    cmp("drive_en rerst", 32'h1, drive_en);
    finish_test();
  end
endmodule
